// File: dv/tagc_ctrl_asserts.sv
// checker: pin and bus-control assertions for the tag directory controller
`default_nettype none
module tagc_ctrl_asserts #(
    parameter int IW = 11
) (
    // clock and reset
    input wire logic               clock,
    input wire logic               rst,
    // request side
    input wire logic               req_valid,
    input wire logic               req_ready,
    input wire tagc_pkg::tagc_op_t req_op,
    input wire logic               req_retry,
    input wire logic               store_mode,
    input wire logic               rsp_valid_q,
    input wire logic               rsp_hit_q,
    // tag RAM pins
    input wire logic [IW-1:0]      index_address,
    input wire logic [15:0]        tag_data_o,
    input wire logic               tag_data_oe,
    input wire logic               select_n,
    input wire logic               read_n,
    input wire logic               low_byte_write_n,
    input wire logic               high_byte_write_n,
    input wire logic               force_hit_override,
    input wire logic               parity_error_n_oe,
    // processor bus
    input wire logic               sync_term,
    input wire logic               bus_error_n,
    input wire logic               processor_stop_n
);
    timeunit 1ns / 1ps;
    logic wr_on;
    logic take;
    assign wr_on = !low_byte_write_n || !high_byte_write_n;
    assign take  = req_valid && req_ready;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    property p_sync; sync_term |=> !sync_term; endproperty
    a_sync: assert property (p_sync) else $error("sync pulse too long");
    property p_sync_sel; sync_term |-> !select_n && read_n; endproperty
    a_sync_sel: assert property (p_sync_sel) else $error("sync outside compare");
    property p_berr; $fell(bus_error_n) |-> rsp_valid_q && !rsp_hit_q && !$past(force_hit_override);
    endproperty
    a_berr: assert property (p_berr) else $error("bus error without miss");
    property p_berr_len; !bus_error_n |=> bus_error_n; endproperty
    a_berr_len: assert property (p_berr_len) else $error("bus error too long");
    property p_stop; processor_stop_n == bus_error_n; endproperty
    a_stop: assert property (p_stop) else $error("stop differs from bus error");
    property p_retry; take && req_retry |=> force_hit_override; endproperty
    a_retry: assert property (p_retry) else $error("retry without override");
    property p_store; take && store_mode |=> force_hit_override; endproperty
    a_store: assert property (p_store) else $error("store mode without override");
    property p_idx; wr_on |-> $stable(index_address) && !select_n && tag_data_oe; endproperty
    a_idx: assert property (p_idx) else $error("index or bus moved in write");
    property p_wr_len; $fell(low_byte_write_n) |-> (!low_byte_write_n)[*4] ##1 low_byte_write_n;
    endproperty
    a_wr_len: assert property (p_wr_len) else $error("write strobe width");
    property p_pe_oe; parity_error_n_oe |-> wr_on; endproperty
    a_pe_oe: assert property (p_pe_oe) else $error("error line pulled outside write");
    property p_valid; tag_data_oe |-> tag_data_o[15]; endproperty
    a_valid: assert property (p_valid) else $error("valid bit low");
    property p_read; !read_n |-> !wr_on && !tag_data_oe; endproperty
    a_read: assert property (p_read) else $error("read with bus driven");
    property p_lat; take && req_op == tagc_pkg::TAGC_OP_COMPARE |-> ##7 rsp_valid_q; endproperty
    a_lat: assert property (p_lat) else $error("compare answer late");
    c_hit: cover property (rsp_valid_q && rsp_hit_q);
    c_berr: cover property ($fell(bus_error_n));
    c_pe: cover property (parity_error_n_oe && !high_byte_write_n);
endmodule : tagc_ctrl_asserts
bind tagc_ctrl tagc_ctrl_asserts #(.IW(IW)) i_chk (.clock, .rst, .req_valid, .req_ready,
    .req_op, .req_retry, .store_mode, .rsp_valid_q, .rsp_hit_q, .index_address, .tag_data_o,
    .tag_data_oe, .select_n, .read_n, .low_byte_write_n, .high_byte_write_n,
    .force_hit_override, .parity_error_n_oe, .sync_term, .bus_error_n, .processor_stop_n);
`default_nettype wire

// File: dv/tagc_dev_model.sv
// behavioural model of the 2K x 18 tag compare RAM seen from its pins
`default_nettype none
module tagc_dev_model #(
    parameter int RESP_NS = 15
) (
    // controls
    input  wire logic        select_n,
    input  wire logic        read_n,
    input  wire logic        low_byte_write_n,
    input  wire logic        high_byte_write_n,
    input  wire logic        reset_n,
    input  wire logic        force_hit_override,
    input  wire logic [10:0] index_address,
    // resolved bus levels
    input  wire logic [15:0] tag_data,
    input  wire logic        parity_error_n,
    // drives
    output wire logic [15:0] dev_tag_o,
    output wire logic        dev_tag_oe,
    output wire logic        hit_a_pull,
    output wire logic        hit_b_pull,
    output wire logic        hit_totem,
    output wire logic        pe_pull
);
    timeunit 1ns / 1ps;
    logic [17:0] mem [2048];
    logic [17:0] cur;
    logic        bad, eq, on, rd, cmp;
    wire  logic  pe_dly;
    // late copy: a release at the strobe's end must not rewrite parity
    assign #1 pe_dly = parity_error_n;
    assign cur = mem[index_address];
    assign bad = (cur[17] != ^cur[15:8]) || (cur[16] != ^cur[7:0]);
    assign eq  = cur[15:0] == tag_data;
    assign on  = !select_n && reset_n && low_byte_write_n && high_byte_write_n;
    assign rd  = on && !read_n;
    assign cmp = on && read_n;
    // select high, reset and writes release every output except hit_totem, which drives high
    assign #(RESP_NS) dev_tag_oe = rd;
    assign #(RESP_NS) dev_tag_o  = cur[15:0];
    assign #(RESP_NS) hit_totem  = !(cmp && (!eq || bad)) && !(rd && bad);
    assign #(RESP_NS) hit_a_pull = !force_hit_override && cmp && (!eq || bad);
    assign #(RESP_NS) hit_b_pull = !force_hit_override && cmp && (!eq || bad);
    assign #(RESP_NS) pe_pull    = (rd || cmp) && bad;
    always @(negedge reset_n) begin
        for (int i = 0; i < 2048; i++) begin
            mem[i] = 18'h00000;
        end
    end
    always @* begin
        if (!select_n && reset_n && !low_byte_write_n) begin
            mem[index_address][7:0] = tag_data[7:0];
            mem[index_address][16]  = ^tag_data[7:0] ^ !pe_dly;
        end
        if (!select_n && reset_n && !high_byte_write_n) begin
            mem[index_address][15:8] = tag_data[15:8];
            mem[index_address][17]   = ^tag_data[15:8] ^ !pe_dly;
        end
    end
endmodule : tagc_dev_model
`default_nettype wire

// File: dv/tb_top.sv
// testbench: tag directory controller against a behavioural tag RAM
`default_nettype none
module tb_top;
    timeunit 1ns / 1ps;
    logic clock, rst, req_valid, req_ready, req_cacheable, req_retry, req_force_pe;
    logic req_mark_dirty, store_mode, rsp_valid_q, rsp_hit_q, rsp_parity_err_q, rsp_dirty_q;
    logic tag_data_oe, select_n, read_n, lo_n, hi_n, tag_reset_n, force_hit_override;
    logic pe_o, pe_oe, pe_i, sync_term, bus_error_n, processor_stop_n, flip, saw_berr;
    logic [10:0] req_index, index_address;
    logic [14:0] req_tag;
    logic [15:0] rsp_tag_q, tag_data_o, tag_data_i;
    wire  logic [15:0] dev_tag_o;
    wire  logic dev_tag_oe, a_pull, b_pull, hit_totem, pe_pull;
    tagc_pkg::tagc_op_t req_op;
    localparam tagc_pkg::tagc_op_t CMP = tagc_pkg::TAGC_OP_COMPARE, RD = tagc_pkg::TAGC_OP_READ;
    localparam tagc_pkg::tagc_op_t FILL = tagc_pkg::TAGC_OP_FILL, CLR = tagc_pkg::TAGC_OP_CLEAR;
    localparam tagc_pkg::tagc_op_t WLO = tagc_pkg::TAGC_OP_WRITE_LO;
    localparam tagc_pkg::tagc_op_t WHI = tagc_pkg::TAGC_OP_WRITE_HI;
    int fails, comparisons, cycles;
    // released bus shows a moving pattern
    assign tag_data_i = tag_data_oe ? tag_data_o : dev_tag_oe ? dev_tag_o : {8{flip, ~flip}};
    assign pe_i = !((pe_oe && !pe_o) || pe_pull);
    tagc_ctrl i_dut (.clock, .rst, .req_valid, .req_ready, .req_op, .req_index, .req_tag,
        .req_retry, .req_cacheable, .req_force_pe, .req_mark_dirty, .store_mode, .rsp_valid_q,
        .rsp_hit_q, .rsp_parity_err_q, .rsp_dirty_q, .rsp_tag_q, .index_address, .tag_data_o,
        .tag_data_oe, .tag_data_i, .select_n, .read_n, .low_byte_write_n(lo_n),
        .high_byte_write_n(hi_n), .tag_reset_n, .force_hit_override, .parity_error_n_o(pe_o),
        .parity_error_n_oe(pe_oe), .parity_error_n_i(pe_i), .hit_od_a(!a_pull),
        .hit_od_b(!b_pull), .hit_totem, .sync_term, .bus_error_n, .processor_stop_n);
    tagc_dev_model #(.RESP_NS(15)) i_dev (.select_n, .read_n, .low_byte_write_n(lo_n),
        .high_byte_write_n(hi_n), .reset_n(tag_reset_n), .force_hit_override, .index_address,
        .tag_data(tag_data_i), .parity_error_n(pe_i), .dev_tag_o, .dev_tag_oe,
        .hit_a_pull(a_pull), .hit_b_pull(b_pull), .hit_totem, .pe_pull);
    // ------------------------
    // clock, watchdog and checking
    // ------------------------
    initial begin
        clock = 1'b0;
        forever #2.5 clock = !clock;
    end
    always @(posedge clock) begin
        flip <= !flip;
        saw_berr <= saw_berr | !bus_error_n;
        cycles++;
        if (cycles == 5000) begin
            fails++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (fails == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one request, then wait for its answer
    task automatic do_req(input tagc_pkg::tagc_op_t op, input logic [10:0] idx,
                          input logic [14:0] tag = 15'h0000);
        int n;
        for (n = 0; req_ready !== 1'b1 && n < 50; n++)
            @(negedge clock);
        req_op = op;
        req_index = idx;
        req_tag = tag;
        req_valid = 1'b1;
        saw_berr = 1'b0;
        @(negedge clock);
        req_valid = 1'b0;
        for (n = 0; rsp_valid_q !== 1'b1 && n < 50; n++)
            @(negedge clock);
        @(negedge clock);
        if (n >= 50) begin
            fails++;
            $display("Error at %0t: no answer", $time);
        end
    endtask : do_req
    // ------------------------
    // scenarios
    // ------------------------
    task automatic t_fill_compare();
        do_req(CMP, 11'h005, 15'h1234);
        chk(rsp_hit_q, 1'b0);
        chk(rsp_parity_err_q, 1'b0);
        chk(saw_berr, 1'b1);
        req_mark_dirty = 1'b1;
        do_req(FILL, 11'h005, 15'h1234);
        req_mark_dirty = 1'b0;
        do_req(CMP, 11'h005, 15'h1234);
        chk(rsp_hit_q, 1'b1);
        chk(rsp_dirty_q, 1'b1);
        chk(saw_berr, 1'b0);
        do_req(CMP, 11'h005, 15'h1334);
        chk(rsp_hit_q, 1'b0);
    endtask : t_fill_compare
    task automatic t_bytes();
        do_req(WLO, 11'h005, 15'h0077);
        do_req(RD, 11'h005);
        chk(rsp_tag_q, 16'h9277);
        do_req(WHI, 11'h005, 15'h4100);
        do_req(RD, 11'h005);
        chk(rsp_tag_q, 16'hC177);
        chk(rsp_hit_q, 1'b1);
    endtask : t_bytes
    task automatic t_parity();
        req_force_pe = 1'b1;
        do_req(WHI, 11'h009);
        req_force_pe = 1'b0;
        do_req(RD, 11'h009);
        chk(rsp_tag_q, 16'h8000);
        chk({rsp_parity_err_q, rsp_hit_q}, 2'h2);
        do_req(CMP, 11'h009);
        chk({rsp_parity_err_q, rsp_hit_q}, 2'h2);
        do_req(WHI, 11'h009);
        do_req(RD, 11'h009);
        chk(rsp_parity_err_q, 1'b0);
        req_force_pe = 1'b1;
        do_req(FILL, 11'h00B, 15'h0003);
        req_force_pe = 1'b0;
        do_req(WLO, 11'h00B, 15'h0003);
        do_req(RD, 11'h00B);
        chk(rsp_parity_err_q, 1'b1);
    endtask : t_parity
    task automatic t_override();
        req_retry = 1'b1;
        do_req(CMP, 11'h005, 15'h0005);
        chk({rsp_hit_q, saw_berr}, 2'h0);
        req_retry = 1'b0;
        req_cacheable = 1'b0;
        do_req(CMP, 11'h005, 15'h0005);
        chk(saw_berr, 1'b0);
        req_cacheable = 1'b1;
        store_mode = 1'b1;
        do_req(CMP, 11'h005, 15'h0005);
        chk(saw_berr, 1'b0);
        store_mode = 1'b0;
    endtask : t_override
    task automatic t_clear();
        do_req(CLR, 11'h000);
        do_req(RD, 11'h005);
        chk(rsp_tag_q, 16'h0000);
        chk(rsp_parity_err_q, 1'b0);
    endtask : t_clear
    initial begin
        {req_valid, req_retry, req_force_pe, req_mark_dirty, store_mode, flip} = 6'h00;
        req_cacheable = 1'b1;
        req_op = CMP;
        req_index = 11'h000;
        req_tag = 15'h0000;
        {fails, comparisons, cycles} = 0;
        rst = 1'b1;
        repeat (6) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        t_fill_compare();
        t_bytes();
        t_parity();
        t_override();
        t_clear();
        end_sim();
    end
endmodule : tb_top
`default_nettype wire

// File: logic/tagc_ctrl.sv
// controller driving a 2K x 18 tag compare RAM through its pins
`default_nettype none
module tagc_ctrl #(
    parameter int ENTRIES = tagc_pkg::ENTRIES,
    parameter int IW      = tagc_pkg::INDEX_W
) (
    // clock and reset
    input  wire logic                         clock,
    input  wire logic                         rst,
    // request side
    input  wire logic                         req_valid,
    output logic                              req_ready,
    input  wire tagc_pkg::tagc_op_t           req_op,
    input  wire logic [IW-1:0]                req_index,
    input  wire logic [tagc_pkg::ADDR_TW-1:0] req_tag,
    input  wire logic                         req_cacheable,
    input  wire logic                         req_retry,
    input  wire logic                         req_force_pe,
    input  wire logic                         req_mark_dirty,
    input  wire logic                         store_mode,
    // answer side
    output logic                              rsp_valid_q,
    output logic                              rsp_hit_q,
    output logic                              rsp_parity_err_q,
    output logic                              rsp_dirty_q,
    output logic [tagc_pkg::TAG_W-1:0]        rsp_tag_q,
    // tag RAM pins
    output logic [IW-1:0]                     index_address,
    output logic [tagc_pkg::TAG_W-1:0]        tag_data_o,
    output logic                              tag_data_oe,
    input  wire logic [tagc_pkg::TAG_W-1:0]   tag_data_i,
    output logic                              select_n,
    output logic                              read_n,
    output logic                              low_byte_write_n,
    output logic                              high_byte_write_n,
    output logic                              tag_reset_n,
    output logic                              force_hit_override,
    output logic                              parity_error_n_o,
    output logic                              parity_error_n_oe,
    input  wire logic                         parity_error_n_i,
    input  wire logic                         hit_od_a,
    input  wire logic                         hit_od_b,
    input  wire logic                         hit_totem,
    // processor bus controls
    output logic                              sync_term,
    output logic                              bus_error_n,
    output logic                              processor_stop_n
);

    typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_WAIT, ST_CLEAR} tagc_state_t;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [tagc_pkg::TAG_W+3:0] meta_q;
    logic [tagc_pkg::TAG_W+3:0] sync_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= {tag_data_i, parity_error_n_i, hit_od_a, hit_od_b, hit_totem};
            sync_q <= meta_q;
        end
    end

    logic [tagc_pkg::TAG_W-1:0] data_s;
    logic                       pe_n_s;
    logic                       hit_s;
    assign data_s = sync_q[tagc_pkg::TAG_W+3:4];
    assign pe_n_s = sync_q[3];
    assign hit_s  = sync_q[2] & sync_q[1] & sync_q[0];

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    tagc_state_t                  state_q, state_d;
    logic [tagc_pkg::CNT_W-1:0]   cnt_q, cnt_d;
    tagc_pkg::tagc_op_t           op_q, op_d;
    logic                         mark_q, mark_d;
    logic                         forced_q, forced_d;
    logic                         pe_req_q, pe_req_d;
    logic [IW-1:0]                idx_d;
    logic [tagc_pkg::TAG_W-1:0]   tag_d;
    logic                         oe_d, sel_n_d, rd_n_d, wlo_n_d, whi_n_d, rst_n_d;
    logic                         fho_d, pe_oe_d, sync_term_d, berr_n_d;
    logic                         rv_d, rh_d, rpe_d, rdy_d;
    logic [tagc_pkg::TAG_W-1:0]   rtag_d;
    logic                         dirty_rd;
    logic                         dm_wr_en, dm_wr_data, dm_rd_en;

    assign req_ready        = (state_q == ST_IDLE);
    assign parity_error_n_o = 1'b0;
    assign processor_stop_n = bus_error_n;

    // ops that strobe data into the array
    function automatic logic is_write(input tagc_pkg::tagc_op_t op);
        return (op == tagc_pkg::TAGC_OP_FILL) || (op == tagc_pkg::TAGC_OP_WRITE_LO) ||
               (op == tagc_pkg::TAGC_OP_WRITE_HI);
    endfunction : is_write

    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        op_d     = op_q;
        mark_d   = mark_q;
        forced_d = forced_q;
        pe_req_d = pe_req_q;
        idx_d    = index_address;
        tag_d    = tag_data_o;
        oe_d     = tag_data_oe;
        sel_n_d  = select_n;
        rd_n_d   = read_n;
        wlo_n_d  = low_byte_write_n;
        whi_n_d  = high_byte_write_n;
        rst_n_d  = tag_reset_n;
        fho_d    = force_hit_override;
        pe_oe_d  = parity_error_n_oe;
        sync_term_d  = 1'b0;
        berr_n_d = 1'b1;
        rv_d     = 1'b0;
        rh_d     = rsp_hit_q;
        rpe_d    = rsp_parity_err_q;
        rtag_d   = rsp_tag_q;
        rdy_d    = rsp_dirty_q;
        dm_wr_en   = 1'b0;
        dm_wr_data = 1'b0;
        dm_rd_en   = 1'b0;
        case (state_q)
            ST_IDLE: begin
                fho_d = store_mode;
                if (req_valid) begin
                    op_d     = req_op;
                    mark_d   = req_mark_dirty;
                    pe_req_d = req_force_pe;
                    idx_d    = req_index;
                    tag_d    = {1'b1, req_tag};
                    forced_d = store_mode | req_retry | ~req_cacheable;
                    fho_d    = store_mode | req_retry | ~req_cacheable;
                    dm_rd_en = 1'b1;
                    if (req_op == tagc_pkg::TAGC_OP_CLEAR) begin
                        rst_n_d = 1'b0;
                        cnt_d   = tagc_pkg::CNT_W'(tagc_pkg::RESET_CYC - 1);
                        state_d = ST_CLEAR;
                    end else begin
                        sel_n_d = 1'b0;
                        if (is_write(req_op)) begin
                            oe_d    = 1'b1;
                            state_d = ST_SETUP;
                        end else if (req_op == tagc_pkg::TAGC_OP_READ) begin
                            oe_d    = 1'b0;
                            rd_n_d  = 1'b0;
                            cnt_d   = tagc_pkg::CNT_W'(tagc_pkg::MATCH_CYC - 1);
                            state_d = ST_WAIT;
                        end else begin
                            oe_d    = 1'b1;
                            sync_term_d = req_cacheable & ~req_retry;
                            cnt_d   = tagc_pkg::CNT_W'(tagc_pkg::MATCH_CYC - 1);
                            state_d = ST_WAIT;
                        end
                    end
                end
            end
            ST_SETUP: begin
                // index already settled a cycle before the strobe falls
                wlo_n_d = ~(op_q != tagc_pkg::TAGC_OP_WRITE_HI);
                whi_n_d = ~(op_q != tagc_pkg::TAGC_OP_WRITE_LO);
                pe_oe_d = pe_req_q;
                cnt_d   = tagc_pkg::CNT_W'(tagc_pkg::WR_CYC - 1);
                state_d = ST_STROBE;
            end
            ST_STROBE: begin
                if (cnt_q == tagc_pkg::CNT_RST) begin
                    wlo_n_d = 1'b1;
                    whi_n_d = 1'b1;
                    pe_oe_d = 1'b0;
                    state_d = ST_HOLD;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            ST_HOLD: begin
                // index and data outlive the strobe by a cycle
                sel_n_d = 1'b1;
                oe_d    = 1'b0;
                fho_d   = store_mode;
                rv_d    = 1'b1;
                if (op_q == tagc_pkg::TAGC_OP_FILL) begin
                    dm_wr_en   = 1'b1;
                    dm_wr_data = mark_q;
                end
                state_d = ST_IDLE;
            end
            ST_WAIT: begin
                // waits out match delay plus the synchroniser
                if (cnt_q == tagc_pkg::CNT_RST) begin
                    sel_n_d = 1'b1;
                    rd_n_d  = 1'b1;
                    oe_d    = 1'b0;
                    fho_d   = store_mode;
                    rv_d    = 1'b1;
                    rh_d    = hit_s;
                    rpe_d   = ~pe_n_s;
                    rtag_d  = data_s;
                    rdy_d   = dirty_rd;
                    if (op_q == tagc_pkg::TAGC_OP_COMPARE) begin
                        berr_n_d = hit_s | forced_q;
                        if (hit_s & mark_q) begin
                            dm_wr_en   = 1'b1;
                            dm_wr_data = 1'b1;
                        end
                    end
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            ST_CLEAR: begin
                if (cnt_q == tagc_pkg::CNT_RST) begin
                    rst_n_d = 1'b1;
                    rv_d    = (op_q == tagc_pkg::TAGC_OP_CLEAR);
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // comes out of reset clearing the directory, so no stale tag can hit
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q            <= ST_CLEAR;
            cnt_q              <= tagc_pkg::CNT_W'(tagc_pkg::RESET_CYC - 1);
            op_q               <= tagc_pkg::TAGC_OP_COMPARE;
            mark_q             <= 1'b0;
            forced_q           <= 1'b0;
            pe_req_q           <= 1'b0;
            index_address      <= '0;
            tag_data_o         <= '0;
            tag_data_oe        <= 1'b0;
            select_n           <= 1'b1;
            read_n             <= 1'b1;
            low_byte_write_n   <= 1'b1;
            high_byte_write_n  <= 1'b1;
            tag_reset_n        <= 1'b0;
            force_hit_override <= 1'b0;
            parity_error_n_oe  <= 1'b0;
            sync_term          <= 1'b0;
            bus_error_n        <= 1'b1;
            rsp_valid_q        <= 1'b0;
            rsp_hit_q          <= 1'b0;
            rsp_parity_err_q   <= 1'b0;
            rsp_tag_q          <= '0;
            rsp_dirty_q        <= 1'b0;
        end else begin
            state_q            <= state_d;
            cnt_q              <= cnt_d;
            op_q               <= op_d;
            mark_q             <= mark_d;
            forced_q           <= forced_d;
            pe_req_q           <= pe_req_d;
            index_address      <= idx_d;
            tag_data_o         <= tag_d;
            tag_data_oe        <= oe_d;
            select_n           <= sel_n_d;
            read_n             <= rd_n_d;
            low_byte_write_n   <= wlo_n_d;
            high_byte_write_n  <= whi_n_d;
            tag_reset_n        <= rst_n_d;
            force_hit_override <= fho_d;
            parity_error_n_oe  <= pe_oe_d;
            sync_term          <= sync_term_d;
            bus_error_n        <= berr_n_d;
            rsp_valid_q        <= rv_d;
            rsp_hit_q          <= rh_d;
            rsp_parity_err_q   <= rpe_d;
            rsp_tag_q          <= rtag_d;
            rsp_dirty_q        <= rdy_d;
        end
    end

    // ----------------------------------------------------------------
    // external dirty flags
    // ----------------------------------------------------------------
    tagc_dirty_mem #(
        .DEPTH (ENTRIES),
        .AW    (IW)
    ) u_dirty (
        .clock     (clock),
        .rst       (rst),
        .wr_en     (dm_wr_en),
        .wr_addr   (index_address),
        .wr_data   (dm_wr_data),
        .rd_en     (dm_rd_en),
        .rd_addr   (req_index),
        .rd_data_q (dirty_rd)
    );

endmodule : tagc_ctrl
`default_nettype wire

// File: logic/tagc_dirty_mem.sv
// dirty-flag memory kept beside the tag directory, registered read data
`default_nettype none
module tagc_dirty_mem #(
    parameter int DEPTH = 2048,
    parameter int AW    = 11
) (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          rst,
    // write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic          wr_data,
    // read port
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic               rd_data_q
);

    logic mem [DEPTH];

    // ----------------------------------------------------------------
    // storage, contents undefined until written
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_data_q <= 1'b0;
        end else if (rd_en) begin
            rd_data_q <= mem[rd_addr];
        end
    end

endmodule : tagc_dirty_mem
`default_nettype wire

// File: pkg/tagc_pkg.sv
// package: constants, timing and operation codes for the tag directory controller
`default_nettype none
package tagc_pkg;

    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int INDEX_W   = 11;
    localparam int ENTRIES   = 2048;
    localparam int TAG_W     = 16;
    localparam int ADDR_TW   = 15;
    localparam int VALID_BIT = 15;

    // ----------------------------------------------------------------
    // timing, clock 200 MHz
    // ----------------------------------------------------------------
    localparam int CLK_NS      = 5;
    localparam int WR_PULSE_NS = 20;
    localparam int MATCH_NS    = 20;
    localparam int RESET_NS    = 60;
    localparam int SYNC_CYC    = 2;
    localparam int CNT_W       = 8;

    // least time rounded up to whole cycles, never below one
    function automatic int cyc_of(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_of

    localparam int WR_CYC    = cyc_of(WR_PULSE_NS);
    localparam int MATCH_CYC = cyc_of(MATCH_NS) + SYNC_CYC;
    localparam int RESET_CYC = cyc_of(RESET_NS);

    // ----------------------------------------------------------------
    // counter end value
    // ----------------------------------------------------------------
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;

    // ----------------------------------------------------------------
    // operations
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        TAGC_OP_COMPARE,
        TAGC_OP_FILL,
        TAGC_OP_WRITE_LO,
        TAGC_OP_WRITE_HI,
        TAGC_OP_READ,
        TAGC_OP_CLEAR
    } tagc_op_t;

endpackage : tagc_pkg
`default_nettype wire
